// [core_timer.sv]
`timescale 1ns/1ps
module core_timer
	import core_timer_pkg::*;
#(
	parameter int unsigned WIDTH = 16
)
(
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic [15:0] ADDR,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [15:0] WDATA,
	output logic [15:0] RDATA,
	input wire logic TIMER_SEL,
	input wire logic CAPTURE_RELOAD_REGISTER_SEL,
	input wire logic CORE_GATE_COUNT_PIN,
	input wire logic EXTERNAL_DIRECTION_PIN,
	input wire logic CAPTURE_TRIGGER_PIN,
	input wire logic FIRST_BLOCK_TIMER_INPUT,
	input wire logic FIRST_BLOCK_DIRECTION_INPUT,
	input wire logic [1:0] CAPTURE_SOURCE,
	input wire logic [1:0] CAPTURE_EDGE,
	input wire logic [WIDTH-1:0] AUXILIARY_TIMER,
	output logic TOGGLE_OUTPUT_PIN,
	output logic OVERFLOW_PULSE,
	output logic TOGGLE_LATCH,
	output logic TOGGLE_SHADOW,
	output logic CAPTURE_EVENT
);
	import core_timer_pkg::*;

	// wrap detection and the read path assume a 16-bit count
	if (WIDTH != 16)
	begin : g_width_check
		$error("core timer width must be 16");
	end

	logic [15:0] ctrl_q;
	logic [WIDTH-1:0] timer_q;
	logic [WIDTH-1:0] capture_reload_register_q;
	logic shadow_q;
	logic [DIV_WIDTH-1:0] div_q;
	logic [3:0] bps_log2;
	logic basic_en;
	logic [7:0] pre_q;
	logic timer_tick;
	logic [2:0] mode;
	logic [2:0] iparam;
	logic run;
	logic count_down;
	logic count_en;
	logic gate_lvl;
	logic gate_rise;
	logic gate_fall;
	logic cap_a_rise;
	logic cap_a_fall;
	logic cap_b_rise;
	logic cap_b_fall;
	logic cap_c_rise;
	logic cap_c_fall;
	logic cap_rise;
	logic cap_fall;
	logic ovf_unf;
	logic wr_ctrl;
	logic wr_timer;
	logic wr_capture_reload_register;
	logic ctrl_edge;
	logic dir_lvl;
	logic clear_now;
	logic reload_now;
	logic [15:0] rdata_q;

	assign mode = ctrl_q[MODE_LSB +: 3];
	assign iparam = ctrl_q[INPUT_PARAM_LSB +: 3];
	assign run = ctrl_q[RUN_BIT];
	assign wr_ctrl = WR_EN && ADDR == CTRL_ADDR;
	assign wr_timer = WR_EN && TIMER_SEL;
	assign wr_capture_reload_register = WR_EN && CAPTURE_RELOAD_REGISTER_SEL;

	// block prescaler: one-cycle enable at the basic clock rate
	always_comb
	begin
		case (ctrl_q[BPS_LSB +: 2])
			2'b00: bps_log2 = BPS_LOG2_00;
			2'b01: bps_log2 = BPS_LOG2_01;
			2'b10: bps_log2 = BPS_LOG2_10;
			default: bps_log2 = BPS_LOG2_11;
		endcase
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!NRST)
			div_q <= '0;
		else
			div_q <= div_q + DIV_WIDTH'(1);
	end

	// a changing divisor may stretch one period; harmless for a free counter
	assign basic_en = (div_q[3:0] & ((4'h1 << bps_log2) - 4'h1)) == 4'h0;

	// input prescaler 2^iparam counted in basic clocks
	always_ff @(posedge REF_CLK)
	begin
		if (!NRST)
			pre_q <= '0;
		else if (basic_en)
			pre_q <= pre_q + 8'h1;
	end

	assign timer_tick = basic_en && ((pre_q & ((8'h1 << iparam) - 8'h1)) == 8'h0);

	edge_sampler gate_smp
	(
		.clk(REF_CLK),
		.nrst(NRST),
		.sample_en(basic_en),
		.pin(CORE_GATE_COUNT_PIN),
		.level(gate_lvl),
		.rise(gate_rise),
		.fall(gate_fall)
	);

	edge_sampler cap_pin_smp
	(
		.clk(REF_CLK),
		.nrst(NRST),
		.sample_en(basic_en),
		.pin(CAPTURE_TRIGGER_PIN),
		.level(),
		.rise(cap_a_rise),
		.fall(cap_a_fall)
	);

	edge_sampler cap_in_smp
	(
		.clk(REF_CLK),
		.nrst(NRST),
		.sample_en(basic_en),
		.pin(FIRST_BLOCK_TIMER_INPUT),
		.level(),
		.rise(cap_b_rise),
		.fall(cap_b_fall)
	);

	edge_sampler cap_dir_smp
	(
		.clk(REF_CLK),
		.nrst(NRST),
		.sample_en(basic_en),
		.pin(FIRST_BLOCK_DIRECTION_INPUT),
		.level(),
		.rise(cap_c_rise),
		.fall(cap_c_fall)
	);

	// the direction pin obeys the same sampling limits as the gate and count pins
	edge_sampler dir_smp
	(
		.clk(REF_CLK),
		.nrst(NRST),
		.sample_en(basic_en),
		.pin(EXTERNAL_DIRECTION_PIN),
		.level(dir_lvl),
		.rise(),
		.fall()
	);

	// count direction, software bit optionally xored with the sampled pin
	always_comb
	begin
		if (ctrl_q[EXT_DIR_EN_BIT])
			count_down = ctrl_q[DIR_BIT] ^ dir_lvl;
		else
			count_down = ctrl_q[DIR_BIT];
	end

	always_comb
	begin
		ctrl_edge = 1'b0;
		case (iparam)
			EDGE_RISE: ctrl_edge = gate_rise;
			EDGE_FALL: ctrl_edge = gate_fall;
			EDGE_ANY: ctrl_edge = gate_rise | gate_fall;
			default: ctrl_edge = 1'b0;
		endcase
	end

	always_comb
	begin
		count_en = 1'b0;
		case (mode)
			MODE_TIMER: count_en = run && timer_tick;
			MODE_COUNTER: count_en = run && ctrl_edge;
			MODE_GATED_LOW: count_en = run && !gate_lvl && timer_tick;
			MODE_GATED_HIGH: count_en = run && gate_lvl && timer_tick;
			default: count_en = 1'b0;
		endcase
	end

	assign ovf_unf = count_en && (count_down ? timer_q == '0 : &timer_q);
	assign clear_now = CAPTURE_EVENT && ctrl_q[CLEAR_EN_BIT];
	assign reload_now = ovf_unf && ctrl_q[RELOAD_EN_BIT];

	// capture trigger selection on the chosen source and edges
	always_comb
	begin
		case (CAPTURE_SOURCE)
			2'b01: cap_rise = cap_b_rise;
			2'b10: cap_rise = cap_c_rise;
			2'b11: cap_rise = cap_b_rise | cap_c_rise;
			default: cap_rise = cap_a_rise;
		endcase
		case (CAPTURE_SOURCE)
			2'b01: cap_fall = cap_b_fall;
			2'b10: cap_fall = cap_c_fall;
			2'b11: cap_fall = cap_b_fall | cap_c_fall;
			default: cap_fall = cap_a_fall;
		endcase
	end

	assign CAPTURE_EVENT = (CAPTURE_EDGE[0] & cap_rise) | (CAPTURE_EDGE[1] & cap_fall);

	// control register; hardware owns only the toggle latch bit
	always_ff @(posedge REF_CLK)
	begin
		if (!NRST)
			ctrl_q <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl_q <= WDATA & CTRL_WMASK;
		else if (ovf_unf)
			ctrl_q[TOGGLE_BIT] <= ~ctrl_q[TOGGLE_BIT];
	end

	// shadow follows one clock late, except on software writes
	always_ff @(posedge REF_CLK)
	begin
		if (!NRST)
			shadow_q <= 1'b0;
		else if (wr_ctrl)
			shadow_q <= WDATA[TOGGLE_BIT];
		else
			shadow_q <= ctrl_q[TOGGLE_BIT];
	end

	// core timer: write wins, then clear, then reload, then count
	always_ff @(posedge REF_CLK)
	begin
		if (!NRST)
			timer_q <= TIMER_RESET;
		else if (wr_timer)
			timer_q <= WDATA[WIDTH-1:0];
		else if (clear_now)
			timer_q <= '0;
		else if (reload_now)
			timer_q <= capture_reload_register_q;
		else if (count_en)
			timer_q <= count_down ? timer_q - WIDTH'(1) : timer_q + WIDTH'(1);
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!NRST)
			capture_reload_register_q <= CAPTURE_RELOAD_REGISTER_RESET;
		else if (wr_capture_reload_register)
			capture_reload_register_q <= WDATA[WIDTH-1:0];
		else if (CAPTURE_EVENT)
			capture_reload_register_q <= AUXILIARY_TIMER;
	end

	// read data from a flop: the word stands one cycle after the strobe is taken
	always_ff @(posedge REF_CLK)
	begin
		if (!NRST)
			rdata_q <= 16'h0000;
		else if (!RD_EN)
			rdata_q <= 16'h0000;
		else if (TIMER_SEL)
			rdata_q <= timer_q;
		else if (CAPTURE_RELOAD_REGISTER_SEL)
			rdata_q <= capture_reload_register_q;
		else if (ADDR == CTRL_ADDR)
			rdata_q <= ctrl_q;
		else
			rdata_q <= 16'h0000;
	end

	assign RDATA = rdata_q;

	assign TOGGLE_OUTPUT_PIN = ctrl_q[OUT_EN_BIT] ? ctrl_q[TOGGLE_BIT] : 1'b1;
	assign OVERFLOW_PULSE = ovf_unf;
	assign TOGGLE_LATCH = ctrl_q[TOGGLE_BIT];
	assign TOGGLE_SHADOW = shadow_q;
endmodule : core_timer

// [core_timer_chk.sv]
`timescale 1ns/1ps
module core_timer_chk
	import core_timer_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic [15:0] ADDR,
	input wire logic WR_EN,
	input wire logic [15:0] WDATA,
	input wire logic TIMER_SEL,
	input wire logic CAPTURE_RELOAD_REGISTER_SEL,
	input wire logic TOGGLE_OUTPUT_PIN,
	input wire logic OVERFLOW_PULSE,
	input wire logic TOGGLE_LATCH,
	input wire logic TOGGLE_SHADOW
);
	logic [15:0] ctrl_q;
	logic cw;
	// control mirror; bit 10 is ignored here since hardware also moves it
	assign cw = WR_EN && ADDR == CTRL_ADDR;
	always_ff @(posedge REF_CLK)
		if (!NRST)
			ctrl_q <= CTRL_RESET;
		else if (cw)
			ctrl_q <= WDATA;
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);
	chk_out_high: assert property (!ctrl_q[9] |-> TOGGLE_OUTPUT_PIN) else $error("pin not high");
	chk_out_follow: assert property (ctrl_q[9] |-> TOGGLE_OUTPUT_PIN == TOGGLE_LATCH) else $error("pin wrong");
	chk_latch_flip: assert property (OVERFLOW_PULSE && !cw |=> TOGGLE_LATCH != $past(TOGGLE_LATCH))
		else $error("latch kept");
	chk_latch_hold: assert property (!OVERFLOW_PULSE && !cw |=> $stable(TOGGLE_LATCH)) else $error("latch moved");
	chk_shadow_lag: assert property (!cw |=> TOGGLE_SHADOW == $past(TOGGLE_LATCH)) else $error("shadow late");
	chk_sw_latch: assert property (cw |=> TOGGLE_LATCH == $past(WDATA[10]) && TOGGLE_SHADOW == TOGGLE_LATCH)
		else $error("latch write lost");
	chk_stop_quiet: assert property (!ctrl_q[6] |-> !OVERFLOW_PULSE) else $error("stopped timer wrapped");
	chk_pulse_gap: assert property (OVERFLOW_PULSE |=> !OVERFLOW_PULSE) else $error("pulse too long");
endmodule : core_timer_chk
bind core_timer core_timer_chk i_chk (.REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR), .WR_EN(WR_EN), .WDATA(WDATA),
	.TIMER_SEL(TIMER_SEL), .CAPTURE_RELOAD_REGISTER_SEL(CAPTURE_RELOAD_REGISTER_SEL), .TOGGLE_OUTPUT_PIN(TOGGLE_OUTPUT_PIN),
	.OVERFLOW_PULSE(OVERFLOW_PULSE), .TOGGLE_LATCH(TOGGLE_LATCH), .TOGGLE_SHADOW(TOGGLE_SHADOW));

// [core_timer_pkg.sv]
package core_timer_pkg;
	localparam logic [15:0] CTRL_ADDR = 16'hff48;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'hdfff;
	// control field positions
	localparam int unsigned INPUT_PARAM_LSB = 0;
	localparam int unsigned MODE_LSB = 3;
	localparam int unsigned RUN_BIT = 6;
	localparam int unsigned DIR_BIT = 7;
	localparam int unsigned EXT_DIR_EN_BIT = 8;
	localparam int unsigned OUT_EN_BIT = 9;
	localparam int unsigned TOGGLE_BIT = 10;
	localparam int unsigned BPS_LSB = 11;
	localparam int unsigned CLEAR_EN_BIT = 14;
	localparam int unsigned RELOAD_EN_BIT = 15;
	localparam logic [15:0] TIMER_RESET = 16'h0000;
	localparam logic [15:0] CAPTURE_RELOAD_REGISTER_RESET = 16'h0000;
	typedef enum logic [2:0]
	{
		MODE_TIMER = 3'h0,
		MODE_COUNTER = 3'h1,
		MODE_GATED_LOW = 3'h2,
		MODE_GATED_HIGH = 3'h3
	} mode_t;
	typedef enum logic [2:0]
	{
		EDGE_NONE = 3'h0,
		EDGE_RISE = 3'h1,
		EDGE_FALL = 3'h2,
		EDGE_ANY = 3'h3
	} edge_sel_t;
	// block prescaler divisors, as log2
	localparam logic [3:0] BPS_LOG2_00 = 4'h2;
	localparam logic [3:0] BPS_LOG2_01 = 4'h1;
	localparam logic [3:0] BPS_LOG2_10 = 4'h4;
	localparam logic [3:0] BPS_LOG2_11 = 4'h3;
	localparam int unsigned DIV_WIDTH = 12;
endpackage : core_timer_pkg

// [edge_sampler.sv]
`timescale 1ns/1ps
// samples a pin on the basic clock enable; an edge needs two differing samples
module edge_sampler
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic sample_en,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic cur_q;
	logic prev_q;
	logic [1:0] seen_q;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			cur_q <= 1'b0;
			prev_q <= 1'b0;
			seen_q <= 2'h0;
		end
		else if (sample_en)
		begin
			cur_q <= pin;
			prev_q <= cur_q;
			seen_q <= {seen_q[0], 1'b1};
		end
	end

	// the reset value is no sample, so a pin idling high gives no false edge
	assign level = cur_q;
	assign rise = sample_en & seen_q[1] & cur_q & ~prev_q;
	assign fall = sample_en & seen_q[1] & ~cur_q & prev_q;
endmodule : edge_sampler

// [pin_source.sv]
`timescale 1ns/1ps
module pin_source
(
	input wire logic clk,
	input wire logic [1:0] pin_mode,
	output logic gate_pin,
	output logic dir_pin
);
	logic [2:0] half_q = 3'h0;
	// levels last four clocks, two samples even at the fastest prescale
	always @(negedge clk)
		half_q <= half_q + 3'h1;
	assign gate_pin = pin_mode[1] ? half_q[2] : pin_mode[0];
	assign dir_pin = pin_mode[0];
endmodule : pin_source

// [tb_core_timer_with_capture_reload.sv]
`timescale 1ns/1ps
module tb_core_timer_with_capture_reload;
	import core_timer_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [15:0] aux = 16'h2468;
	logic [1:0] sel = 2'h0;
	logic [1:0] pin_mode = 2'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic cap_pin = 1'b0;
	logic fb_in = 1'b0;
	logic fb_dir = 1'b0;
	logic [1:0] cap_src = 2'h0;
	logic [1:0] cap_edge = 2'h1;
	logic gate_pin, dir_pin, out_pin, pulse, latch, cap_ev;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	always #2.5 clk = !clk;
	core_timer i_dut (.REF_CLK(clk), .NRST(nrst), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata),
		.RDATA(rdata), .TIMER_SEL(sel[1]), .CAPTURE_RELOAD_REGISTER_SEL(sel[0]), .CORE_GATE_COUNT_PIN(gate_pin),
		.EXTERNAL_DIRECTION_PIN(dir_pin), .CAPTURE_TRIGGER_PIN(cap_pin), .FIRST_BLOCK_TIMER_INPUT(fb_in),
		.FIRST_BLOCK_DIRECTION_INPUT(fb_dir), .CAPTURE_SOURCE(cap_src), .CAPTURE_EDGE(cap_edge),
		.AUXILIARY_TIMER(aux),
		.TOGGLE_OUTPUT_PIN(out_pin), .OVERFLOW_PULSE(pulse), .TOGGLE_LATCH(latch), .TOGGLE_SHADOW(),
		.CAPTURE_EVENT(cap_ev));
	pin_source i_pins (.clk(clk), .pin_mode(pin_mode), .gate_pin(gate_pin), .dir_pin(dir_pin));
	task automatic end_sim();
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	// one bus cycle; s picks timer (2) or capture/reload (1), else control
	task automatic acc(input logic we, input logic [1:0] s, input logic [15:0] d, output logic [15:0] q);
		@(negedge clk);
		sel = s;
		addr = s == 2'h0 ? CTRL_ADDR : 16'h0000;
		wdata = d;
		{wr_en, rd_en} = {we, !we};
		@(negedge clk);
		{wr_en, rd_en} = 2'h0;
		q = rdata;
	endtask : acc
	task automatic t_span(input logic [15:0] c, input logic [1:0] m, input int lo, input int hi);
		logic signed [15:0] v;
		pin_mode = m;
		acc(1, 2'h0, 16'h0000, v);
		acc(1, 2'h2, 16'h8000, v);
		acc(1, 2'h0, c, v);
		repeat (80) @(negedge clk);
		acc(0, 2'h2, 16'h0000, v);
		v = v - 16'sh8000;
		checks_done++;
		if ((v >= lo && v <= hi) !== 1'b1)
		begin
			failures++;
			$display("Error count step expected %0d..%0d seen %0d", lo, hi, v);
		end
	endtask : t_span
	task automatic t_event(input logic [15:0] c, input logic [15:0] st, input logic [15:0] e, input logic cap);
		logic [15:0] v;
		int n;
		aux = aux + 16'h0101;
		acc(1, 2'h0, 16'h0000, v);
		acc(1, 2'h2, st, v);
		acc(1, 2'h1, 16'h1234, v);
		acc(1, 2'h0, c, v);
		if (!cap)
			chk("out pin", 16'h0000, {15'h0, out_pin});
		cap_pin = cap;
		for (n = 0; n < 100 && (cap ? cap_ev : pulse) !== 1'b1; n++)
			@(negedge clk);
		chk("event", 16'h0001, {15'h0, cap ? cap_ev : pulse});
		acc(0, 2'h2, 16'h0000, v);
		chk("timer", e, v);
		if (cap)
			acc(0, 2'h1, 16'h0000, v);
		chk(cap ? "capture" : "out pin", cap ? aux : 16'h0001, cap ? v : {15'h0, out_pin});
		cap_pin = 1'b0;
		repeat (8) @(negedge clk);
	endtask : t_event
	// first-block capture lines: src picks the line, edg bit0 rising, bit1 falling
	task automatic t_capsrc(input logic [1:0] src, input logic [1:0] edg);
		logic [15:0] v;
		logic [15:0] e;
		cap_src = src;
		cap_edge = edg;
		acc(1, 2'h0, 16'h0800, v);
		acc(1, 2'h1, 16'h0000, v);
		aux = aux + 16'h0101;
		{fb_dir, fb_in} = src;
		repeat (8) @(negedge clk);
		acc(0, 2'h1, 16'h0000, v);
		e = edg[0] ? aux : 16'h0000;
		chk("capture rise", e, v);
		aux = aux + 16'h0101;
		{fb_dir, fb_in} = 2'h0;
		repeat (8) @(negedge clk);
		acc(0, 2'h1, 16'h0000, v);
		e = edg[1] ? aux : e;
		chk("capture fall", e, v);
	endtask : t_capsrc
	initial
	begin
		logic [15:0] v;
		repeat (6) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		acc(0, 2'h0, 16'h0000, v);
		chk("control", CTRL_RESET, v);
		chk("out pin", 16'h0001, {15'h0, out_pin});
		t_span(16'h0840, 2'h0, 35, 45);
		t_span(16'h08c0, 2'h0, -45, -35);
		t_span(16'h0940, 2'h1, -45, -35);
		t_span(16'h09c0, 2'h1, 35, 45);
		t_span(16'h0800, 2'h0, 0, 0);
		t_span(16'h0850, 2'h1, 0, 0);
		t_span(16'h0858, 2'h1, 35, 45);
		t_span(16'h0818, 2'h1, 0, 0);
		t_span(16'h0848, 2'h2, 0, 0);
		t_span(16'h0849, 2'h2, 8, 11);
		t_span(16'h084a, 2'h2, 8, 11);
		t_span(16'h084b, 2'h2, 17, 21);
		t_span(16'h0040, 2'h0, 17, 22);
		t_span(16'h1040, 2'h0, 3, 6);
		t_span(16'h1840, 2'h0, 8, 11);
		t_span(16'h0841, 2'h0, 17, 22);
		t_event(16'h0a40, 16'hfffe, 16'h0000, 1'b0);
		t_event(16'h8a40, 16'hfffe, 16'h1234, 1'b0);
		t_event(16'h8ac0, 16'h0001, 16'h1234, 1'b0);
		t_event(16'h4800, 16'h5555, 16'h0000, 1'b1);
		t_event(16'h0800, 16'h5555, 16'h5555, 1'b1);
		t_capsrc(2'h1, 2'h2);
		t_capsrc(2'h2, 2'h3);
		t_capsrc(2'h3, 2'h1);
		end_sim();
	end
endmodule : tb_core_timer_with_capture_reload
